// >>> core/lnk_slot_pkg.sv
package lnk_slot_pkg;
  // Register offsets (byte offsets as printed)
  localparam logic [7:0] LINK_STATE_REPORT_OFS = 8'h52;
  localparam logic [7:0] CONNECTOR_CAPS_OFS = 8'h54;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h60;
  localparam logic [7:0] IRQ_ENABLE_OFS = 8'h64;
  localparam logic [7:0] IRQ_CLEAR_OFS = 8'h68;
  localparam logic [7:0] EE_LOAD_OFS = 8'h6c;

  localparam logic [3:0] LINK_RATE_2G5 = 4'h1;
  localparam logic [5:0] LANE_COUNT_RST = 6'h00;
  localparam logic [7:0] PLV_RST = 8'h00;
  localparam logic [1:0] PLS_RST = 2'h0;
  localparam logic [12:0] PCN_RST = 13'h0000;
  localparam logic [2:0] IRQ_RST = 3'h0;
  localparam logic [1:0] PORT_UP = 2'h0;

  // Interrupt status bit positions
  localparam int IRQ_TRAIN_FAULT = 0;
  localparam int IRQ_MSG_SENT = 1;
  localparam int IRQ_DL_UP = 2;

  typedef struct packed {
    logic [2:0] rsvd;
    logic shared_refclk;
    logic training_active_flag;
    logic training_fault_flag;
    logic [5:0] negotiated_lane_count;
    logic [3:0] link_rate_code;
  } link_state_t;

  typedef struct packed {
    logic [12:0] physical_connector_number;
    logic no_cmd_done_support;
    logic interlock_present;
    logic [1:0] power_limit_scale;
    logic [7:0] power_limit_value;
    logic [6:0] presence_bits;
  } conn_caps_t;

  typedef struct packed {
    logic [7:0] power_limit_value;
    logic [1:0] power_limit_scale;
  } power_msg_t;

  typedef enum logic [1:0] {
    MSG_IDLE = 2'b00,
    MSG_SEND = 2'b01,
    MSG_WAIT = 2'b11
  } msg_state_t;
endpackage : lnk_slot_pkg

// >>> core/sync2.sv
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q, meta_d, out_q, out_d;

  always_comb begin
    meta_d = d;
    out_d = meta_q;
  end

  // No reset: a strap must already be through both stages when reset ends
  always_ff @(posedge clk) begin
    meta_q <= meta_d;
    out_q <= out_d;
  end

  assign q = out_q;
endmodule // sync2
`default_nettype wire

// >>> core/lnk_slot_regs.sv
`timescale 1ns/1ps
`default_nettype none
module lnk_slot_regs (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Port identity and capability
  input wire logic [1:0] PORT_INDEX,
  input wire logic SLOT_IMPLEMENTED,
  // Straps from pins
  input wire logic UPSTREAM_REFCLK_STRAP,
  input wire logic DOWNSTREAM_REFCLK_STRAP,
  // Link layer status
  input wire logic [5:0] NEGOTIATED_LANE_COUNT,
  input wire logic LANE_COUNT_VALID,
  input wire logic TRAINING_ERROR,
  input wire logic TRAINING_ACTIVE,
  input wire logic DL_UP,
  // Register port
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  // Power limit message
  output logic MSG_VALID,
  output lnk_slot_pkg::power_msg_t MSG_DATA,
  input wire logic MSG_READY,
  // Interrupt
  output logic IRQ
);
  logic strap_up_s, strap_dn_s;

  sync2 #(.W(1)) u_sync_up (
    .clk(CLK),
    .d(UPSTREAM_REFCLK_STRAP),
    .q(strap_up_s)
  );

  sync2 #(.W(1)) u_sync_dn (
    .clk(CLK),
    .d(DOWNSTREAM_REFCLK_STRAP),
    .q(strap_dn_s)
  );

  // Register state
  logic [5:0] lanes_q, lanes_d;
  logic fault_q, fault_d;
  logic train_q, train_d;
  logic refclk_q, refclk_d;
  logic strap_pend_q, strap_pend_d;
  logic [7:0] plv_q, plv_d;
  logic [1:0] pls_q, pls_d;
  logic [12:0] pcn_q, pcn_d;
  logic dlup_q, dlup_d;
  logic [2:0] irq_st_q, irq_st_d;
  logic [2:0] irq_en_q, irq_en_d;
  logic irq_q, irq_d;
  logic [31:0] rdata_q, rdata_d;
  logic msg_req;
  lnk_slot_pkg::msg_state_t mst_q, mst_d;
  lnk_slot_pkg::power_msg_t msg_q, msg_d;
  logic msg_again_q, msg_again_d;
  lnk_slot_pkg::link_state_t ls_view;
  lnk_slot_pkg::conn_caps_t cc_view;
  lnk_slot_pkg::conn_caps_t wr_view;
  logic msg_valid_q, msg_valid_d;
  logic wr_caps, wr_ee, dl_rise;

  always_comb begin
    ls_view.rsvd = '0;
    ls_view.shared_refclk = refclk_q;
    ls_view.training_active_flag = train_q;
    ls_view.training_fault_flag = fault_q;
    ls_view.negotiated_lane_count = lanes_q;
    ls_view.link_rate_code = lnk_slot_pkg::LINK_RATE_2G5;
    cc_view.presence_bits = '0;
    cc_view.interlock_present = 1'b0;
    cc_view.no_cmd_done_support = 1'b0;
    cc_view.power_limit_value = SLOT_IMPLEMENTED ? plv_q : '0;
    cc_view.power_limit_scale = SLOT_IMPLEMENTED ? pls_q : '0;
    cc_view.physical_connector_number = SLOT_IMPLEMENTED ? pcn_q : '0;
    wr_view = WDATA;
  end

  always_comb begin
    wr_caps = WR && (ADDR == lnk_slot_pkg::CONNECTOR_CAPS_OFS);
    wr_ee = WR && (ADDR == lnk_slot_pkg::EE_LOAD_OFS);
    dl_rise = DL_UP && !dlup_q;
    msg_req = wr_caps || dl_rise;
  end

  // Link status and slot capability state
  always_comb begin
    lanes_d = LANE_COUNT_VALID ? NEGOTIATED_LANE_COUNT : lanes_q;
    fault_d = fault_q || TRAINING_ERROR;
    train_d = TRAINING_ACTIVE;
    strap_pend_d = 1'b0;
    refclk_d = refclk_q;
    // An EEPROM override in the load cycle wins over the strap
    if (wr_ee) begin
      refclk_d = WDATA[0];
    end else if (strap_pend_q) begin
      refclk_d = (PORT_INDEX == lnk_slot_pkg::PORT_UP) ? strap_up_s : strap_dn_s;
    end
    plv_d = plv_q;
    pls_d = pls_q;
    pcn_d = pcn_q;
    if (wr_caps && SLOT_IMPLEMENTED) begin
      plv_d = wr_view.power_limit_value;
      pls_d = wr_view.power_limit_scale;
      pcn_d = wr_view.physical_connector_number;
    end
    dlup_d = DL_UP;
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      lanes_q <= lnk_slot_pkg::LANE_COUNT_RST;
      fault_q <= 1'b0;
      train_q <= 1'b0;
      refclk_q <= 1'b0;
      strap_pend_q <= 1'b1;
      plv_q <= lnk_slot_pkg::PLV_RST;
      pls_q <= lnk_slot_pkg::PLS_RST;
      pcn_q <= lnk_slot_pkg::PCN_RST;
      dlup_q <= 1'b0;
    end else begin
      lanes_q <= lanes_d;
      fault_q <= fault_d;
      train_q <= train_d;
      refclk_q <= refclk_d;
      strap_pend_q <= strap_pend_d;
      plv_q <= plv_d;
      pls_q <= pls_d;
      pcn_q <= pcn_d;
      dlup_q <= dlup_d;
    end
  end

  // Power limit message sender; a request during a send is queued once
  always_comb begin
    mst_d = mst_q;
    msg_d = msg_q;
    msg_again_d = msg_again_q || (msg_req && mst_q != lnk_slot_pkg::MSG_IDLE);
    case (mst_q)
      lnk_slot_pkg::MSG_IDLE: begin
        if (msg_req || msg_again_q) begin
          mst_d = lnk_slot_pkg::MSG_SEND;
          msg_again_d = 1'b0;
        end
      end
      lnk_slot_pkg::MSG_SEND: begin
        msg_d.power_limit_value = cc_view.power_limit_value;
        msg_d.power_limit_scale = cc_view.power_limit_scale;
        mst_d = lnk_slot_pkg::MSG_WAIT;
      end
      lnk_slot_pkg::MSG_WAIT: begin
        if (MSG_READY) begin
          mst_d = lnk_slot_pkg::MSG_IDLE;
        end
      end
      default: begin
        mst_d = lnk_slot_pkg::MSG_IDLE;
      end
    endcase
    msg_valid_d = (mst_d == lnk_slot_pkg::MSG_WAIT);
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      mst_q <= lnk_slot_pkg::MSG_IDLE;
      msg_valid_q <= 1'b0;
      msg_q <= '0;
      msg_again_q <= 1'b0;
    end else begin
      mst_q <= mst_d;
      msg_valid_q <= msg_valid_d;
      msg_q <= msg_d;
      msg_again_q <= msg_again_d;
    end
  end

  // Valid comes from its own flop, not from a state decode
  assign MSG_VALID = msg_valid_q;
  assign MSG_DATA = msg_q;

  // Interrupts and read data
  always_comb begin
    irq_st_d = irq_st_q;
    if (WR && ADDR == lnk_slot_pkg::IRQ_CLEAR_OFS) begin
      irq_st_d = irq_st_q & ~WDATA[2:0];
    end
    if (TRAINING_ERROR) begin
      irq_st_d[lnk_slot_pkg::IRQ_TRAIN_FAULT] = 1'b1;
    end
    if (MSG_VALID && MSG_READY) begin
      irq_st_d[lnk_slot_pkg::IRQ_MSG_SENT] = 1'b1;
    end
    if (dl_rise) begin
      irq_st_d[lnk_slot_pkg::IRQ_DL_UP] = 1'b1;
    end
    irq_en_d = irq_en_q;
    if (WR && ADDR == lnk_slot_pkg::IRQ_ENABLE_OFS) begin
      irq_en_d = WDATA[2:0];
    end
    irq_d = |(irq_st_d & irq_en_d);
    rdata_d = '0;
    if (RD) begin
      if (ADDR == lnk_slot_pkg::LINK_STATE_REPORT_OFS) begin
        rdata_d = {16'h0000, ls_view};
      end else if (ADDR == lnk_slot_pkg::CONNECTOR_CAPS_OFS) begin
        rdata_d = cc_view;
      end else if (ADDR == lnk_slot_pkg::IRQ_STATUS_OFS) begin
        rdata_d = {29'h0, irq_st_q};
      end else if (ADDR == lnk_slot_pkg::IRQ_ENABLE_OFS) begin
        rdata_d = {29'h0, irq_en_q};
      end else if (ADDR == lnk_slot_pkg::EE_LOAD_OFS) begin
        rdata_d = {31'h0, refclk_q};
      end else begin
        rdata_d = '0;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      irq_st_q <= lnk_slot_pkg::IRQ_RST;
      irq_en_q <= lnk_slot_pkg::IRQ_RST;
      irq_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      irq_st_q <= irq_st_d;
      irq_en_q <= irq_en_d;
      irq_q <= irq_d;
      rdata_q <= rdata_d;
    end
  end

  assign RDATA = rdata_q;
  assign IRQ = irq_q;

  rate_fixed_a: assert property (@(posedge CLK) disable iff (RST)
    RD && ADDR == lnk_slot_pkg::LINK_STATE_REPORT_OFS |=> RDATA[3:0] == 4'h1)
    else $error("link rate not 0x1");
  fault_sticky_a: assert property (@(posedge CLK) disable iff (RST)
    TRAINING_ERROR |=> fault_q [*2])
    else $error("training fault not held");
  train_follow_a: assert property (@(posedge CLK) disable iff (RST)
    1'b1 |=> train_q == $past(TRAINING_ACTIVE))
    else $error("training flag wrong");
  presence_zero_a: assert property (@(posedge CLK) disable iff (RST)
    RD && ADDR == lnk_slot_pkg::CONNECTOR_CAPS_OFS |=> RDATA[6:0] == 7'h00 && RDATA[18:17] == 2'h0)
    else $error("hot-plug bits not zero");
  no_slot_zero_a: assert property (@(posedge CLK) disable iff (RST)
    RD && ADDR == lnk_slot_pkg::CONNECTOR_CAPS_OFS && !SLOT_IMPLEMENTED |=> RDATA[31:7] == '0)
    else $error("slot fields not zero");
  msg_issue_a: assert property (@(posedge CLK) disable iff (RST)
    msg_req && mst_q == lnk_slot_pkg::MSG_IDLE |-> ##2 MSG_VALID)
    else $error("power message not sent");
  limit_write_a: assert property (@(posedge CLK) disable iff (RST)
    wr_caps && SLOT_IMPLEMENTED |=> plv_q == $past(WDATA[14:7]) && pls_q == $past(WDATA[16:15]))
    else $error("power limit not stored");
  rsvd_zero_a: assert property (@(posedge CLK) disable iff (RST)
    RD && ADDR == lnk_slot_pkg::LINK_STATE_REPORT_OFS |=> RDATA[31:13] == '0)
    else $error("reserved bits set");
  lane_capture_a: assert property (@(posedge CLK) disable iff (RST)
    LANE_COUNT_VALID |=> lanes_q == $past(NEGOTIATED_LANE_COUNT))
    else $error("lane count not captured");
  lane_hold_a: assert property (@(posedge CLK) disable iff (RST)
    !LANE_COUNT_VALID |=> $stable(lanes_q))
    else $error("lane count changed");
  fault_irq_a: assert property (@(posedge CLK) disable iff (RST)
    TRAINING_ERROR |=> irq_st_q[lnk_slot_pkg::IRQ_TRAIN_FAULT])
    else $error("fault status lost");
  no_slot_lock_a: assert property (@(posedge CLK) disable iff (RST)
    wr_caps && !SLOT_IMPLEMENTED |=> $stable(plv_q) && $stable(pls_q) && $stable(pcn_q))
    else $error("locked slot fields written");
  msg_hold_a: assert property (@(posedge CLK) disable iff (RST)
    MSG_VALID && !MSG_READY |=> MSG_VALID && $stable(MSG_DATA))
    else $error("power message dropped");
  rdata_idle_a: assert property (@(posedge CLK) disable iff (RST)
    !RD |=> RDATA == '0)
    else $error("read data without read");
  ee_override_a: assert property (@(posedge CLK) disable iff (RST)
    wr_ee |=> refclk_q == $past(WDATA[0]))
    else $error("refclk override lost");
endmodule // lnk_slot_regs
`default_nettype wire

// >>> verification/power_msg_sink.sv
`timescale 1ns/1ps
`default_nettype none
module power_msg_sink (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Message link
  input wire logic msg_valid,
  input wire lnk_slot_pkg::power_msg_t msg_data,
  output logic msg_ready,
  // Pace and capture
  input wire logic [3:0] lag,
  output int got,
  output lnk_slot_pkg::power_msg_t last
);
  logic [3:0] wait_q;
  // Ready only after lag+1 cycles of a pending message
  always_ff @(posedge clk) begin
    if (rst) begin
      wait_q <= 4'h0;
      msg_ready <= 1'b0;
      got <= 0;
    end else if (msg_ready && msg_valid) begin
      msg_ready <= 1'b0;
      wait_q <= 4'h0;
      got <= got + 1;
      last <= msg_data;
    end else if (msg_valid && wait_q == lag) begin
      msg_ready <= 1'b1;
    end else if (msg_valid) begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule // power_msg_sink
`default_nettype wire

// >>> verification/pcie_link_status_slot_caps_bench.sv
`timescale 1ns/1ps
`default_nettype none
module pcie_link_status_slot_caps_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] port_index = 2'h0;
  logic slot_impl = 1'b1, us_strap = 1'b1, ds_strap = 1'b0;
  logic [5:0] lanes = 6'h00;
  logic lanes_ok = 1'b0, t_err = 1'b0, t_act = 1'b0, dl_up = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic wr = 1'b0, rd = 1'b0, msg_valid, msg_ready, irq;
  logic [3:0] lag = 4'h0;
  lnk_slot_pkg::power_msg_t msg_data, last;
  int got, n0;
  int failures = 0;
  int samples_checked = 0;

  initial forever #5 clk = ~clk;

  lnk_slot_regs i_lnk_slot_regs (.CLK(clk), .RST(rst), .PORT_INDEX(port_index),
    .SLOT_IMPLEMENTED(slot_impl), .UPSTREAM_REFCLK_STRAP(us_strap),
    .DOWNSTREAM_REFCLK_STRAP(ds_strap), .NEGOTIATED_LANE_COUNT(lanes),
    .LANE_COUNT_VALID(lanes_ok), .TRAINING_ERROR(t_err), .TRAINING_ACTIVE(t_act),
    .DL_UP(dl_up), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .MSG_VALID(msg_valid), .MSG_DATA(msg_data), .MSG_READY(msg_ready), .IRQ(irq));
  power_msg_sink i_power_msg_sink (.clk(clk), .rst(rst), .msg_valid(msg_valid),
    .msg_data(msg_data), .msg_ready(msg_ready), .lag(lag), .got(got), .last(last));

  task automatic complete_run;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic do_reset;
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
  endtask

  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(what, exp, rdata);
  endtask

  // Waits for one more message than n0 and compares its fields
  task automatic msg_chk(input string what, input logic [9:0] exp);
    for (int i = 0; i < 40 && got == n0; i++) @(posedge clk);
    chk(what, {22'h0, exp}, (got == n0) ? 32'hffffffff : {22'h0, last});
  endtask

  task automatic t_link_fields;
    @(posedge clk);
    lanes <= 6'h08;
    lanes_ok <= 1'b1;
    t_act <= 1'b1;
    @(posedge clk);
    lanes_ok <= 1'b0;
    lanes <= 6'h3f;
    repeat (3) @(posedge clk);
    rd_chk("lanes training", 8'h52, 32'h00001881);
    wr32(8'h52, 32'hffffffff);
    rd_chk("link ro write", 8'h52, 32'h00001881);
    @(posedge clk);
    t_err <= 1'b1;
    t_act <= 1'b0;
    @(posedge clk);
    t_err <= 1'b0;
    repeat (3) @(posedge clk);
    rd_chk("fault flag", 8'h52, 32'h00001481);
  endtask

  task automatic t_caps;
    logic [31:0] w;
    for (int s = 0; s < 4; s++) begin
      w = (32'(8'h40 + s) << 7) | (32'(s) << 15);
      n0 = got;
      wr32(8'h54, w);
      msg_chk("msg scale", {8'(8'h40 + s), 2'(s)});
      rd_chk("caps scale", 8'h54, w);
    end
    @(posedge clk);
    lag <= 4'h3;
    n0 = got;
    wr32(8'h54, 32'hffffffff);
    msg_chk("msg slow", 10'h3ff);
    rd_chk("caps ones", 8'h54, 32'hfff9ff80);
    @(posedge clk);
    slot_impl <= 1'b0;
    rd_chk("caps noslot", 8'h54, 32'h0);
    n0 = got;
    wr32(8'h54, 32'hffffffff);
    msg_chk("msg noslot", 10'h000);
    slot_impl <= 1'b1;
  endtask

  task automatic t_dl_up;
    // Second write lands while the first message waits: one repeat follows
    n0 = got;
    wr32(8'h54, 32'h00000080);
    wr32(8'h54, 32'h00009080);
    msg_chk("msg first", {8'h01, 2'h0});
    n0 = got;
    msg_chk("msg queued", {8'h21, 2'h1});
    n0 = got;
    wr32(8'h54, 32'h00009080);
    msg_chk("msg write", {8'h21, 2'h1});
    n0 = got;
    dl_up <= 1'b1;
    msg_chk("msg dl up", {8'h21, 2'h1});
    repeat (20) @(posedge clk);
    chk("one msg per rise", n0 + 1, got);
  endtask

  task automatic t_irq;
    rd_chk("irq status", 8'h60, 32'h7);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr32(8'h64, 32'h7);
    repeat (2) @(posedge clk);
    #1;
    chk("irq on", 32'h1, {31'h0, irq});
    wr32(8'h68, 32'h7);
    repeat (2) @(posedge clk);
    #1;
    chk("irq off", 32'h0, {31'h0, irq});
    rd_chk("irq cleared", 8'h60, 32'h0);
    rd_chk("unmapped", 8'h40, 32'h0);
  endtask

  task automatic t_reset_view;
    rd_chk("link reset", 8'h52, 32'h00001001);
    rd_chk("caps reset", 8'h54, 32'h0);
  endtask

  task automatic t_downstream;
    @(posedge clk);
    port_index <= 2'h1;
    do_reset();
    rd_chk("link downstream", 8'h52, 32'h00000001);
    wr32(8'h6c, 32'h1);
    rd_chk("refclk override", 8'h52, 32'h00001001);
  endtask

  initial begin
    do_reset();
    t_reset_view();
    t_link_fields();
    t_caps();
    t_dl_up();
    t_irq();
    t_downstream();
    complete_run();
  end

  initial begin
    #100us;
    failures++;
    complete_run();
  end
endmodule // pcie_link_status_slot_caps_bench
`default_nettype wire
